// >>> inc/ccps_map.svh
// register map, field positions and timing counts of the cable power sequencer
`ifndef CCPS_MAP_SVH
`define CCPS_MAP_SVH

// ------------------------------------------------------------
// bus
// ------------------------------------------------------------
`define CCPS_ADDR_W 12
`define CCPS_STATUS_OFFS 12'h000
`define CCPS_STATUS_RST 32'h0000_0010

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define CCPS_BIT_POWER 0
`define CCPS_BIT_GROUND 1
`define CCPS_BIT_WAIT 2
`define CCPS_BIT_SENSE 4
`define CCPS_BIT_SEEN 5
`define CCPS_BIT_FOUND 6

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CCPS_CLK_MHZ 10
`define CCPS_WAIT_MS 2000
`define CCPS_WAIT_CYC (`CCPS_WAIT_MS * 1000 * `CCPS_CLK_MHZ)
`define CCPS_WAIT_W 25
`define CCPS_LOSS_US 100
`define CCPS_LOSS_CYC (`CCPS_LOSS_US * `CCPS_CLK_MHZ)
`define CCPS_LOSS_W 10

`endif

// >>> inc/ccps_pkg.sv
// types of the cable power sequencer
`include "ccps_map.svh"

package ccps_pkg;

    typedef enum logic [1:0] {
        CCPS_SENSE,
        CCPS_WAIT_CLK,
        CCPS_CLK_SEEN
    } ccps_state_t;

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } ccps_sync_t;

    typedef struct packed {
        logic prev;
        logic [`CCPS_LOSS_W-1:0] idle;
        logic alive;
    } ccps_mon_t;

    typedef struct packed {
        ccps_state_t state;
        logic power;
        logic ground;
        logic found;
        logic [`CCPS_WAIT_W-1:0] wait_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ccps_top_t;

endpackage

// >>> src/ccps_sync.sv
// two-stage synchroniser for the cable sense and pixel clock pins
`timescale 1ns/1ps

module ccps_sync
    import ccps_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, low
    input wire logic [2:0] pin_async, // raw pin levels
    output logic [2:0] pin_sync // levels safe to use
);

    ccps_sync_t st;
    ccps_sync_t next_st;

    // first stage feeds only the second stage
    always_comb begin
        next_st = st;
        next_st.stage1 = pin_async;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync = st.stage2;

endmodule

// >>> src/ccps_clk_mon.sv
// pixel clock activity monitor: alive while transitions keep arriving
`timescale 1ns/1ps
`include "ccps_map.svh"

module ccps_clk_mon
    import ccps_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, low
    input wire logic clk_level, // synchronised divided pixel clock
    output logic clk_alive // transition seen within the loss window
);

    localparam logic [`CCPS_LOSS_W-1:0] LOSS_LAST = `CCPS_LOSS_W'(`CCPS_LOSS_CYC - 1);

    ccps_mon_t st;
    ccps_mon_t next_st;
    logic edge_seen;

    always_comb begin
        next_st = st;
        edge_seen = clk_level ^ st.prev;
        next_st.prev = clk_level;
        if (edge_seen) begin
            next_st.idle = '0;
            next_st.alive = 1'b1;
        end else if (st.idle == LOSS_LAST) begin
            next_st.alive = 1'b0;
        end else begin
            next_st.idle = st.idle + `CCPS_LOSS_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign clk_alive = st.alive;

    a_alive_after_edge: assert property (@(posedge pclk) disable iff (!presetn)
        edge_seen |=> clk_alive)
        else $error("activity not flagged after a pixel clock edge");

    a_alive_drops: assert property (@(posedge pclk) disable iff (!presetn)
        (!edge_seen && st.idle == LOSS_LAST) |=> !clk_alive)
        else $error("activity still flagged after the loss window");

endmodule

// >>> src/ccps_top.sv
// cable power sequencer: sense, power-up wait, clock watch and apb status
`timescale 1ns/1ps
`include "ccps_map.svh"

module ccps_top
    import ccps_pkg::*;
#(
    parameter int unsigned WAIT_CYCLES = `CCPS_WAIT_CYC // power-up wait in clocks
)
(
    input wire logic pclk, // 10 MHz bus clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [`CCPS_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data, unused
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic [31:0] prdata, // apb read data
    input wire logic sense_camera, // pin: powered camera impedance
    input wire logic sense_short, // pin: short on power wires
    input wire logic pixel_clk_div, // pin: divided camera pixel clock
    output logic cable_power_en, // switch cable power on
    output logic cable_gnd_en // ground cable power wires
);

    localparam logic [`CCPS_WAIT_W-1:0] WAIT_LAST = `CCPS_WAIT_W'(WAIT_CYCLES - 1);

    // ------------------------------------------------------------
    // pin synchronisation and clock watch
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic camera_s;
    logic short_s;
    logic clk_alive;

    ccps_sync u_sync (
        .pclk (pclk),
        .presetn (presetn),
        .pin_async ({pixel_clk_div, sense_short, sense_camera}),
        .pin_sync (pins_s)
    );

    assign camera_s = pins_s[0];
    assign short_s = pins_s[1];

    ccps_clk_mon u_mon (
        .pclk (pclk),
        .presetn (presetn),
        .clk_level (pins_s[2]),
        .clk_alive (clk_alive)
    );

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    function automatic logic [31:0] status_word(input ccps_top_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`CCPS_BIT_POWER] = s.power;
        w[`CCPS_BIT_GROUND] = s.ground;
        w[`CCPS_BIT_WAIT] = (s.state == CCPS_WAIT_CLK);
        w[`CCPS_BIT_SENSE] = (s.state == CCPS_SENSE);
        w[`CCPS_BIT_SEEN] = (s.state == CCPS_CLK_SEEN);
        w[`CCPS_BIT_FOUND] = s.found;
        return w;
    endfunction

    function automatic logic status_hit(input logic [`CCPS_ADDR_W-1:0] a);
        return a == `CCPS_STATUS_OFFS;
    endfunction

    // ------------------------------------------------------------
    // state and next state
    // ------------------------------------------------------------
    ccps_top_t st;
    ccps_top_t next_st;
    logic setup;

    assign setup = psel && !penable;

    always_comb begin
        next_st = st;
        case (st.state)
            CCPS_SENSE: begin
                next_st.power = 1'b0;
                next_st.found = 1'b0;
                if (short_s) begin
                    // a short wins: never power into a legacy cable
                    next_st.ground = 1'b1;
                end else if (camera_s) begin
                    next_st.ground = 1'b0;
                    next_st.power = 1'b1;
                    next_st.found = 1'b1;
                    next_st.wait_cnt = '0;
                    next_st.state = CCPS_WAIT_CLK;
                end else begin
                    // ground released so a new attachment can be sensed
                    next_st.ground = 1'b0;
                end
            end
            CCPS_WAIT_CLK: begin
                // full wait regardless of early clock activity
                if (st.wait_cnt == WAIT_LAST) begin
                    if (clk_alive) begin
                        next_st.state = CCPS_CLK_SEEN;
                    end else begin
                        next_st.state = CCPS_SENSE;
                        next_st.power = 1'b0;
                        next_st.found = 1'b0;
                    end
                end else begin
                    next_st.wait_cnt = st.wait_cnt + `CCPS_WAIT_W'(1);
                end
            end
            CCPS_CLK_SEEN: begin
                if (!clk_alive) begin
                    next_st.state = CCPS_SENSE;
                    next_st.power = 1'b0;
                    next_st.found = 1'b0;
                end
            end
            default: begin
                next_st.state = CCPS_SENSE;
                next_st.power = 1'b0;
                next_st.ground = 1'b0;
                next_st.found = 1'b0;
            end
        endcase

        // apb: ready in the first access cycle, no wait states
        if (setup) begin
            next_st.pready = 1'b1;
            next_st.pslverr = pwrite || !status_hit(paddr);
            next_st.prdata = (!pwrite && status_hit(paddr)) ? status_word(st) : 32'h0000_0000;
        end else begin
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign prdata = st.prdata;
    assign cable_power_en = st.power;
    assign cable_gnd_en = st.ground;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_setup_read;
        psel && !penable && !pwrite && status_hit(paddr);
    endsequence

    sequence seq_enter_wait;
        st.state == CCPS_SENSE && !short_s && camera_s;
    endsequence

    sequence seq_clock_lost;
        st.state == CCPS_CLK_SEEN && !clk_alive;
    endsequence

    sequence seq_short_seen;
        st.state == CCPS_SENSE && short_s;
    endsequence

    sequence seq_wait_done;
        st.state == CCPS_WAIT_CLK && st.wait_cnt == WAIT_LAST;
    endsequence

    sequence seq_bad_read;
        psel && !penable && !pwrite && !status_hit(paddr);
    endsequence

    sequence seq_valid_read;
        pready && !pslverr;
    endsequence

    a_sense_power_off: assert property (
        st.state == CCPS_SENSE |-> !cable_power_en)
        else $error("cable power on in the sense state");

    a_camera_powers_up: assert property (
        seq_enter_wait |=> cable_power_en && st.state == CCPS_WAIT_CLK && !cable_gnd_en)
        else $error("camera impedance did not apply power");

    a_short_grounds: assert property (
        st.state == CCPS_SENSE && short_s |=> cable_gnd_en && !cable_power_en && st.state == CCPS_SENSE)
        else $error("short did not ground the wires");

    a_idle_stays_sense: assert property (
        st.state == CCPS_SENSE && !short_s && !camera_s |=> st.state == CCPS_SENSE && !cable_gnd_en)
        else $error("left sense with nothing attached");

    a_wait_holds: assert property (
        seq_enter_wait |=> (st.state == CCPS_WAIT_CLK && cable_power_en)[*8])
        else $error("wait state left too early");

    a_wait_count: assert property (
        st.state == CCPS_WAIT_CLK && st.wait_cnt != WAIT_LAST |=> st.state == CCPS_WAIT_CLK
            && st.wait_cnt == $past(st.wait_cnt) + `CCPS_WAIT_W'(1))
        else $error("wait counter did not advance");

    a_clock_loss_off: assert property (
        seq_clock_lost |=> !cable_power_en && st.state == CCPS_SENSE)
        else $error("power kept after pixel clock loss");

    a_wait_end_choice: assert property (
        st.state == CCPS_WAIT_CLK && st.wait_cnt == WAIT_LAST |=>
            (st.state == CCPS_CLK_SEEN) == $past(clk_alive) && cable_power_en == $past(clk_alive))
        else $error("wrong exit from the wait state");

    a_status_read: assert property (
        seq_setup_read |=> pready && !pslverr && prdata[`CCPS_BIT_POWER] == $past(st.power)
            && prdata[`CCPS_BIT_GROUND] == $past(st.ground)
            && prdata[`CCPS_BIT_WAIT] == ($past(st.state) == CCPS_WAIT_CLK)
            && prdata[`CCPS_BIT_SENSE] == ($past(st.state) == CCPS_SENSE)
            && prdata[`CCPS_BIT_SEEN] == ($past(st.state) == CCPS_CLK_SEEN)
            && prdata[`CCPS_BIT_FOUND] == $past(st.found))
        else $error("status word does not match the machine");

    a_one_state_bit: assert property (
        $onehot(status_word(st) & 32'h0000_0034) && (status_word(st) & 32'hFFFF_FF88) == 32'h0000_0000)
        else $error("state bits not one-hot or reserved bit set");

    a_power_not_ground: assert property (
        !(cable_power_en && cable_gnd_en))
        else $error("power and ground driven together");

    a_found_tracks: assert property (
        st.found == (st.state != CCPS_SENSE))
        else $error("camera found flag out of step");

    a_write_refused: assert property (
        psel && !penable && pwrite |=> pready && pslverr)
        else $error("write to read-only status not refused");

    // ------------------------------------------------------------
    // state path and bus answer checks
    // ------------------------------------------------------------

    a_short_beats_camera: assert property (
        seq_short_seen ##0 camera_s |=> st.state == CCPS_SENSE && cable_gnd_en && !cable_power_en)
        else $error("camera impedance won over a short");

    a_ground_released: assert property (
        st.state == CCPS_SENSE && !short_s |=> !cable_gnd_en)
        else $error("ground kept without a short");

    a_ground_only_sense: assert property (
        cable_gnd_en |-> st.state == CCPS_SENSE)
        else $error("wires grounded outside the sense state");

    a_power_in_wait: assert property (
        st.state == CCPS_WAIT_CLK |-> cable_power_en)
        else $error("power off while waiting for the clock");

    a_power_in_seen: assert property (
        st.state == CCPS_CLK_SEEN |-> cable_power_en)
        else $error("power off in the clock seen state");

    a_wait_starts_zero: assert property (
        seq_enter_wait |=> st.wait_cnt == '0)
        else $error("wait counter not cleared on entry");

    a_wait_dead_clock: assert property (
        seq_wait_done ##0 !clk_alive |=> st.state == CCPS_SENSE && !cable_power_en)
        else $error("power kept with no clock after the wait");

    a_wait_live_clock: assert property (
        seq_wait_done ##0 clk_alive |=> st.state == CCPS_CLK_SEEN && cable_power_en)
        else $error("live clock did not reach the steady state");

    a_seen_holds: assert property (
        st.state == CCPS_CLK_SEEN && clk_alive |=> st.state == CCPS_CLK_SEEN && cable_power_en)
        else $error("steady state left with the clock running");

    a_seen_via_wait: assert property (
        st.state == CCPS_CLK_SEEN && $past(st.state) != CCPS_CLK_SEEN |-> $past(st.state) == CCPS_WAIT_CLK)
        else $error("steady state entered without the wait");

    a_wait_via_sense: assert property (
        st.state == CCPS_WAIT_CLK && $past(st.state) != CCPS_WAIT_CLK |->
            $past(st.state) == CCPS_SENSE && $past(camera_s) && !$past(short_s))
        else $error("wait state entered without a powered camera");

    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    a_ready_after_setup: assert property (
        pready |-> $past(psel && !penable))
        else $error("ready without a setup cycle");

    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("error flagged without ready");

    a_bad_read_refused: assert property (
        seq_bad_read |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    a_rdata_holds: assert property (
        !(psel && !penable) |=> $stable(prdata))
        else $error("read data changed without a setup");

    a_read_reserved_zero: assert property (
        seq_valid_read |-> (prdata & 32'hFFFF_FF88) == 32'h0000_0000)
        else $error("reserved status bit read as one");

    a_read_one_state: assert property (
        seq_valid_read |-> $onehot(prdata & 32'h0000_0034))
        else $error("status read without exactly one state bit");

    a_read_found_bit: assert property (
        seq_valid_read |-> prdata[`CCPS_BIT_FOUND] != prdata[`CCPS_BIT_SENSE])
        else $error("found bit disagrees with the sense bit");

    a_read_power_bit: assert property (
        seq_valid_read ##0 prdata[`CCPS_BIT_POWER] |-> !prdata[`CCPS_BIT_SENSE])
        else $error("power bit read in the sense state");

    a_read_ground_bit: assert property (
        seq_valid_read ##0 prdata[`CCPS_BIT_GROUND] |-> prdata[`CCPS_BIT_SENSE] && !prdata[`CCPS_BIT_POWER])
        else $error("ground bit read outside sensing");

endmodule

// >>> verification/ccps_camera.sv
// behavioural camera and cable seen from the far side of the power sequencer
`timescale 1ns/1ps

module ccps_camera (
    input wire logic pclk, // bench clock
    input wire logic presetn, // async reset, low
    input wire logic plugged, // powered camera on the cable
    input wire logic shorted, // legacy cable shorting the power wires
    input wire logic healthy, // camera drives its pixel clock once powered
    input wire logic power_in, // cable power from the block
    output logic sense_camera, // camera impedance present
    output logic sense_short, // short present
    output logic pixel_clk_div // divided pixel clock
);
    logic [1:0] div;

    assign sense_camera = plugged;
    assign sense_short = shorted;

    // a stopped camera clock just freezes at its last level, no activity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 2'h0;
            pixel_clk_div <= 1'b0;
        end else if (plugged && healthy && power_in) begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                pixel_clk_div <= ~pixel_clk_div;
            end
        end
    end
endmodule

// >>> verification/tb_top.sv
// self-checking bench of the cable power sequencer over apb
`timescale 1ns/1ps

module tb_top;
    import ccps_pkg::*;
    // short power-up wait so a run stays small
    localparam int unsigned WAIT = 50;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, pslverr, cable_power_en, cable_gnd_en;
    logic sense_camera, sense_short, pixel_clk_div;
    logic [31:0] prdata;
    logic [31:0] d;
    logic e;
    logic cam = 1'b0;
    logic shrt = 1'b0;
    logic run = 1'b1;
    int fails = 0;
    int compares = 0;

    ccps_top #(.WAIT_CYCLES(WAIT)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .sense_camera(sense_camera), .sense_short(sense_short), .pixel_clk_div(pixel_clk_div),
        .cable_power_en(cable_power_en), .cable_gnd_en(cable_gnd_en));
    ccps_camera i_cam (.pclk(pclk), .presetn(presetn), .plugged(cam), .shorted(shrt), .healthy(run),
        .power_in(cable_power_en), .sense_camera(sense_camera), .sense_short(sense_short),
        .pixel_clk_div(pixel_clk_div));

    initial begin
        forever #50 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // answer taken at the rising edge that completes the access
    task automatic apb(input logic [11:0] a, input logic wr, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= 32'hFFFF_FFFF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                give_verdict();
            end
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic status(input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(12'h000, 1'b0, rd, er);
        chk("status", rd, exp);
        chk("status err", {31'h0, er}, 32'h0000_0000);
    endtask

    task automatic wait_pwr(input logic lvl, input int lim);
        int n;
        n = 0;
        @(posedge pclk);
        while (cable_power_en !== lvl) begin
            n++;
            if (n > lim) begin
                fails++;
                give_verdict();
            end
            @(posedge pclk);
        end
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        status(32'h0000_0010);
        apb(12'h000, 1'b1, d, e);
        chk("write err", {31'h0, e}, 32'h0000_0001);
        chk("write data", d, 32'h0000_0000);
        apb(12'h004, 1'b0, d, e);
        chk("unmapped err", {31'h0, e}, 32'h0000_0001);
        repeat (200) @(posedge pclk);
        status(32'h0000_0010);
        chk("idle power", {31'h0, cable_power_en}, 32'h0000_0000);
        shrt <= 1'b1;
        cam <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("short gnd", {31'h0, cable_gnd_en}, 32'h0000_0001);
        chk("short power", {31'h0, cable_power_en}, 32'h0000_0000);
        status(32'h0000_0012);
        shrt <= 1'b0;
        wait_pwr(1'b1, 10);
        status(32'h0000_0045);
        repeat (3) @(posedge pclk);
        chk("gnd released", {31'h0, cable_gnd_en}, 32'h0000_0000);
        repeat (WAIT + 10) @(posedge pclk);
        status(32'h0000_0061);
        cam <= 1'b0;
        repeat (900) @(posedge pclk);
        chk("power before loss", {31'h0, cable_power_en}, 32'h0000_0001);
        wait_pwr(1'b0, 200);
        status(32'h0000_0010);
        run <= 1'b0;
        cam <= 1'b1;
        wait_pwr(1'b1, 10);
        cam <= 1'b0;
        repeat (WAIT - 12) @(posedge pclk);
        chk("power in wait", {31'h0, cable_power_en}, 32'h0000_0001);
        status(32'h0000_0045);
        wait_pwr(1'b0, 20);
        status(32'h0000_0010);
        run <= 1'b1;
        cam <= 1'b1;
        wait_pwr(1'b1, 10);
        presetn <= 1'b0;
        cam <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reset power", {31'h0, cable_power_en}, 32'h0000_0000);
        presetn <= 1'b1;
        status(32'h0000_0010);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        give_verdict();
    end
endmodule
